// ==== shared/cipher_sync_pkg.sv ====
// Constants and types shared by the cipher mode controller and its keystream sequencer.
// Assumes one clock domain and a frame-start pulse from the local MAC timing logic.
package cipher_sync_pkg;

	localparam int KEY_W = 128;
	localparam int OLD_KEY_W = 64;
	localparam int IV_W = 35;
	localparam int FN_W = 4;
	localparam int MF_W = 24;
	localparam int IV_MF_LSB = 4;
	localparam int IV_LBN_LSB = 28;
	localparam int IV_LBN_W = 4;
	localparam int IV_PAD_W = 3;
	localparam int KS_CNT_W = 10;
	localparam int SEG_IDX_W = 9;

	localparam logic [KS_CNT_W-1:0] SEG_BITS = 10'h168;
	localparam logic [KS_CNT_W-1:0] PAIR_BITS = 10'h2d0;
	localparam logic [IV_LBN_W-1:0] LBN_MAX = 4'hf;
	localparam logic [2:0] REQ_TRIES = 3'h5;
	localparam logic [2:0] CONF_TRIES = 3'h6;
	localparam logic [FN_W-1:0] FN_RESET = 4'h0;
	localparam logic [MF_W-1:0] MF_RESET = 24'h000000;

	typedef enum logic [2:0] {
		MSG_NONE = 3'b000,
		MSG_ON_REQUEST = 3'b001,
		MSG_ON_CONFIRM = 3'b010,
		MSG_ON_REJECT = 3'b011,
		MSG_ON_GRANT = 3'b100,
		MSG_OFF_REQUEST = 3'b101,
		MSG_OFF_CONFIRM = 3'b110,
		MSG_OFF_GRANT = 3'b111
	} msg_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_P_REQ = 3'b001,
		ST_P_GRANT = 3'b010,
		ST_F_CONF = 3'b011,
		ST_F_REJECT = 3'b100
	} state_t;

endpackage

// ==== shared/ks_ctrl_if.sv ====
// Link between the mode controller and the keystream sequencer.
// Both ends run on the same clock; no crossing inside.
`timescale 1ns/1ps
interface ks_ctrl_if;
	import cipher_sync_pkg::*;
	logic load;
	logic [FN_W-1:0] fn;
	logic [MF_W-1:0] mf;
	logic advanced;
	logic [IV_LBN_W-1:0] logical_bearer_number;
	logic fixed_role;
	logic bit_in;
	logic bit_in_valid;
	logic kload;
	logic [IV_W-1:0] iv;
	logic seg_valid;
	logic seg_bit;
	logic seg_second;
	logic seg_tx;
	logic [SEG_IDX_W-1:0] seg_idx;

	modport ctrl (
		output load, fn, mf, advanced, logical_bearer_number, fixed_role, bit_in, bit_in_valid,
		input kload, iv, seg_valid, seg_bit, seg_second, seg_tx, seg_idx
	);
	modport seq (
		input load, fn, mf, advanced, logical_bearer_number, fixed_role, bit_in, bit_in_valid,
		output kload, iv, seg_valid, seg_bit, seg_second, seg_tx, seg_idx
	);
endinterface

// ==== verilog/keystream_sequencer.sv ====
// Builds the per-frame init vector and splits 720 generator bits into two segments.
// Expects one load pulse per encrypted frame, with frame numbers already updated.
`timescale 1ns/1ps
module keystream_sequencer
	import cipher_sync_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Controller link
	ks_ctrl_if.seq ks
);

	logic [IV_W-1:0] iv_q, iv_d;
	logic kload_q, kload_d;
	logic [KS_CNT_W-1:0] cnt_q, cnt_d;
	logic busy_q, busy_d;
	logic sv_q, sv_d;
	logic sb_q, sb_d;
	logic ss_q, ss_d;
	logic st_q, st_d;
	logic [SEG_IDX_W-1:0] si_q, si_d;
	logic [IV_LBN_W-1:0] lbn_star;
	logic second;

	always_comb begin
		lbn_star = ks.advanced ? LBN_MAX - ks.logical_bearer_number : '0;
		iv_d = iv_q;
		kload_d = 1'b0;
		cnt_d = cnt_q;
		busy_d = busy_q;
		sv_d = 1'b0;
		sb_d = sb_q;
		ss_d = ss_q;
		st_d = st_q;
		si_d = si_q;
		second = (cnt_q >= SEG_BITS);
		if (ks.load) begin
			// Fresh vector each frame, so successive frames use successive values
			iv_d = {{IV_PAD_W{1'b0}}, lbn_star, ks.mf, ks.fn};
			kload_d = 1'b1;
			cnt_d = '0;
			busy_d = 1'b1;
		end else if (busy_q && ks.bit_in_valid) begin
			sv_d = 1'b1;
			sb_d = ks.bit_in;
			ss_d = second;
			st_d = ks.fixed_role ^ second;
			si_d = second ? SEG_IDX_W'(cnt_q - SEG_BITS) : SEG_IDX_W'(cnt_q);
			cnt_d = cnt_q + 10'h001;
			if (cnt_q == PAIR_BITS - 10'h001) begin
				busy_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			iv_q <= '0;
			kload_q <= 1'b0;
			cnt_q <= '0;
			busy_q <= 1'b0;
			sv_q <= 1'b0;
			sb_q <= 1'b0;
			ss_q <= 1'b0;
			st_q <= 1'b0;
			si_q <= '0;
		end else begin
			iv_q <= iv_d;
			kload_q <= kload_d;
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			sv_q <= sv_d;
			sb_q <= sb_d;
			ss_q <= ss_d;
			st_q <= st_d;
			si_q <= si_d;
		end
	end

	assign ks.iv = iv_q;
	assign ks.kload = kload_q;
	assign ks.seg_valid = sv_q;
	assign ks.seg_bit = sb_q;
	assign ks.seg_second = ss_q;
	assign ks.seg_tx = st_q;
	assign ks.seg_idx = si_q;

endmodule

// ==== verilog/cipher_mode_sync_control.sv ====
// Peer-terminal cipher mode controller: frame counters, mode switch handshake,
// generator loading and keystream segment routing for one connection.
// Assumes frame_start_i, tail messages and generator bits come from same-clock MAC logic.
//
// Functional notes
// - Both ends start in clear mode and switch at agreed frame numbers.
// - Generator gets the shared cipher key: 128 bits new algorithm, 64 bits older.
// - Init vector is 35 bits, bit 0 least significant, depends on bearer.
// - Basic: bits 0-3 frame number, 4-27 multiframe number, 28-34 zero.
// - Advanced: bits 28-31 hold fifteen minus logical bearer number, 32-34 zero.
// - Generator reloads every encrypted frame with that frame's own numbering.
// - Each encrypted frame yields 720 bits: first half segment one, rest segment two.
// - Duplex: fixed side transmits with segment one; portable side transmits with two.
// - Double simplex: segment one serves the first bearer, segment two the second; this block routes duplex only.
// - Switch messages unencrypted; portable even frames late half, fixed odd early half.
// - Only portable initiates; mode covers all bearers, later bearers adopt it.
// - Each segment is 360 bits for the full-slot two-level structure.
`timescale 1ns/1ps
module cipher_mode_sync_control
	import cipher_sync_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Connection setup
	input wire logic fixed_role_i,
	input wire logic advanced_i,
	input wire logic [IV_LBN_W-1:0] logical_bearer_number_i,
	input wire logic key_wide_i,
	input wire logic [KEY_W-1:0] cipher_key_i,
	input wire logic reject_default_i,
	// Frame timing
	input wire logic frame_start_i,
	input wire logic sync_i,
	input wire logic [FN_W-1:0] sync_frame_i,
	input wire logic [MF_W-1:0] sync_multiframe_i,
	// Upper layer
	input wire logic upper_switch_request_i,
	input wire logic upper_target_encrypt_i,
	input wire logic upper_default_key_i,
	output logic upper_switch_confirm_o,
	output logic upper_switch_reject_o,
	output logic upper_switch_indication_o,
	output logic upper_disconnect_indication_o,
	// Tail messages
	input wire logic rx_msg_valid_i,
	input wire logic [2:0] rx_msg_i,
	input wire logic rx_default_key_i,
	output logic tx_msg_valid_o,
	output logic [2:0] tx_msg_o,
	output logic tx_default_key_o,
	output logic tx_second_half_o,
	// Keystream generator
	output logic keystream_generator_load_o,
	output logic [KEY_W-1:0] keystream_generator_key_o,
	output logic [IV_W-1:0] init_vector_o,
	input wire logic keystream_generator_bit_i,
	input wire logic keystream_generator_bit_valid_i,
	// Segment stream and modes
	output logic keystream_segment_valid_o,
	output logic keystream_segment_bit_o,
	output logic keystream_segment_second_o,
	output logic keystream_segment_tx_o,
	output logic [SEG_IDX_W-1:0] keystream_segment_index_o,
	output logic tx_encrypt_o,
	output logic rx_decrypt_o,
	output logic rx_ignore_o,
	output logic frame_even_o
);

	ks_ctrl_if ks ();

	// Frame counters
	logic [FN_W-1:0] fn_q, fn_d;
	logic [MF_W-1:0] mf_q, mf_d;

	always_comb begin
		fn_d = fn_q;
		mf_d = mf_q;
		if (sync_i) begin
			fn_d = sync_frame_i;
			mf_d = sync_multiframe_i;
		end else if (frame_start_i) begin
			fn_d = fn_q + 4'h1;
			if (fn_q == 4'hf) begin
				mf_d = mf_q + 24'h000001;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			fn_q <= FN_RESET;
			mf_q <= MF_RESET;
		end else begin
			fn_q <= fn_d;
			mf_q <= mf_d;
		end
	end

	// Mode switch control
	state_t state_q, state_d;
	logic [2:0] tries_q, tries_d;
	logic target_q, target_d;
	logic pend_q, pend_d;
	logic pend_tgt_q, pend_tgt_d;
	logic pend_dflt_q, pend_dflt_d;
	logic tx_enc_q, tx_enc_d;
	logic rx_dec_q, rx_dec_d;
	logic rx_ign_q, rx_ign_d;
	logic txv_q, txv_d;
	logic [2:0] txm_q, txm_d;
	logic txk_q, txk_d;
	logic cfm_q, cfm_d;
	logic rej_q, rej_d;
	logic ind_q, ind_d;
	logic dis_q, dis_d;
	logic load_q, load_d;
	logic [KEY_W-1:0] key_q, key_d;
	logic even_start, odd_start, rx_req_ok;
	msg_t rx_msg;

	always_comb begin
		rx_msg = msg_t'(rx_msg_i);
		even_start = frame_start_i && !fn_d[0];
		odd_start = frame_start_i && fn_d[0];
		state_d = state_q;
		tries_d = tries_q;
		target_d = target_q;
		pend_d = pend_q;
		pend_tgt_d = pend_tgt_q;
		pend_dflt_d = pend_dflt_q;
		tx_enc_d = tx_enc_q;
		rx_dec_d = rx_dec_q;
		rx_ign_d = rx_ign_q;
		txv_d = 1'b0;
		txm_d = txm_q;
		txk_d = txk_q;
		cfm_d = 1'b0;
		rej_d = 1'b0;
		ind_d = 1'b0;
		dis_d = 1'b0;
		// Requests arrive in even frames only; a stray one outside is not a switch
		rx_req_ok = rx_msg_valid_i && !fn_q[0] &&
			((rx_msg == MSG_ON_REQUEST && !tx_enc_q) ||
			(rx_msg == MSG_OFF_REQUEST && tx_enc_q));
		// Fixed role never initiates; a request while busy is dropped
		if (upper_switch_request_i && !fixed_role_i && state_q == ST_IDLE && !pend_q &&
			upper_target_encrypt_i != tx_enc_q) begin
			pend_d = 1'b1;
			pend_tgt_d = upper_target_encrypt_i;
			pend_dflt_d = upper_default_key_i;
		end
		case (state_q)
			ST_IDLE: begin
				if (fixed_role_i && rx_req_ok) begin
					target_d = (rx_msg == MSG_ON_REQUEST);
					tries_d = 3'h0;
					if (rx_msg == MSG_ON_REQUEST && rx_default_key_i && reject_default_i) begin
						state_d = ST_F_REJECT;
					end else begin
						tx_enc_d = (rx_msg == MSG_ON_REQUEST);
						txk_d = rx_default_key_i;
						state_d = ST_F_CONF;
					end
				end else if (!fixed_role_i && pend_q && even_start) begin
					txv_d = 1'b1;
					txm_d = pend_tgt_q ? MSG_ON_REQUEST : MSG_OFF_REQUEST;
					txk_d = pend_dflt_q;
					target_d = pend_tgt_q;
					tries_d = 3'h1;
					rx_ign_d = 1'b1;
					pend_d = 1'b0;
					state_d = ST_P_REQ;
				end
			end
			ST_P_REQ: begin
				if (rx_msg_valid_i && ((target_q && rx_msg == MSG_ON_CONFIRM) ||
					(!target_q && rx_msg == MSG_OFF_CONFIRM))) begin
					rx_dec_d = target_q;
					rx_ign_d = 1'b0;
					cfm_d = 1'b1;
					state_d = ST_P_GRANT;
				end else if (rx_msg_valid_i && target_q && txk_q && rx_msg == MSG_ON_REJECT) begin
					rx_ign_d = 1'b0;
					cfm_d = 1'b1;
					rej_d = 1'b1;
					state_d = ST_IDLE;
				end else if (even_start) begin
					if (tries_q == REQ_TRIES) begin
						dis_d = 1'b1;
						tx_enc_d = 1'b0;
						rx_dec_d = 1'b0;
						rx_ign_d = 1'b0;
						state_d = ST_IDLE;
					end else begin
						txv_d = 1'b1;
						tries_d = tries_q + 3'h1;
					end
				end
			end
			ST_P_GRANT: begin
				if (even_start) begin
					txv_d = 1'b1;
					txm_d = target_q ? MSG_ON_GRANT : MSG_OFF_GRANT;
					tx_enc_d = target_q;
					state_d = ST_IDLE;
				end
			end
			ST_F_CONF: begin
				if (rx_msg_valid_i && ((target_q && rx_msg == MSG_ON_GRANT) ||
					(!target_q && rx_msg == MSG_OFF_GRANT))) begin
					rx_dec_d = target_q;
					rx_ign_d = 1'b0;
					ind_d = 1'b1;
					state_d = ST_IDLE;
				end else if (odd_start) begin
					if (tries_q == CONF_TRIES) begin
						dis_d = 1'b1;
						tx_enc_d = 1'b0;
						rx_dec_d = 1'b0;
						rx_ign_d = 1'b0;
						state_d = ST_IDLE;
					end else begin
						txv_d = 1'b1;
						txm_d = target_q ? MSG_ON_CONFIRM : MSG_OFF_CONFIRM;
						tries_d = tries_q + 3'h1;
					end
				end else if (even_start) begin
					rx_ign_d = 1'b1;
				end
			end
			ST_F_REJECT: begin
				if (odd_start) begin
					txv_d = 1'b1;
					txm_d = MSG_ON_REJECT;
					txk_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		load_d = frame_start_i && (tx_enc_d || rx_dec_d ||
			(state_d == ST_P_REQ && target_d));
		key_d = key_wide_i ? cipher_key_i :
			{{(KEY_W-OLD_KEY_W){1'b0}}, cipher_key_i[OLD_KEY_W-1:0]};
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			tries_q <= 3'h0;
			target_q <= 1'b0;
			pend_q <= 1'b0;
			pend_tgt_q <= 1'b0;
			pend_dflt_q <= 1'b0;
			tx_enc_q <= 1'b0;
			rx_dec_q <= 1'b0;
			rx_ign_q <= 1'b0;
			txv_q <= 1'b0;
			txm_q <= MSG_NONE;
			txk_q <= 1'b0;
			cfm_q <= 1'b0;
			rej_q <= 1'b0;
			ind_q <= 1'b0;
			dis_q <= 1'b0;
			load_q <= 1'b0;
			key_q <= '0;
		end else begin
			state_q <= state_d;
			tries_q <= tries_d;
			target_q <= target_d;
			pend_q <= pend_d;
			pend_tgt_q <= pend_tgt_d;
			pend_dflt_q <= pend_dflt_d;
			tx_enc_q <= tx_enc_d;
			rx_dec_q <= rx_dec_d;
			rx_ign_q <= rx_ign_d;
			txv_q <= txv_d;
			txm_q <= txm_d;
			txk_q <= txk_d;
			cfm_q <= cfm_d;
			rej_q <= rej_d;
			ind_q <= ind_d;
			dis_q <= dis_d;
			load_q <= load_d;
			key_q <= key_d;
		end
	end

	assign ks.load = load_q;
	assign ks.fn = fn_q;
	assign ks.mf = mf_q;
	assign ks.advanced = advanced_i;
	assign ks.logical_bearer_number = logical_bearer_number_i;
	assign ks.fixed_role = fixed_role_i;
	assign ks.bit_in = keystream_generator_bit_i;
	assign ks.bit_in_valid = keystream_generator_bit_valid_i;

	keystream_sequencer u_seq (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ks(ks)
	);

	assign upper_switch_confirm_o = cfm_q;
	assign upper_switch_reject_o = rej_q;
	assign upper_switch_indication_o = ind_q;
	assign upper_disconnect_indication_o = dis_q;
	// Tail messages stay clear and sit in the role's own half frame
	assign tx_msg_valid_o = txv_q;
	assign tx_msg_o = txm_q;
	assign tx_default_key_o = txk_q;
	assign tx_second_half_o = !fixed_role_i;
	assign keystream_generator_load_o = ks.kload;
	assign keystream_generator_key_o = key_q;
	assign init_vector_o = ks.iv;
	assign keystream_segment_valid_o = ks.seg_valid;
	assign keystream_segment_bit_o = ks.seg_bit;
	assign keystream_segment_second_o = ks.seg_second;
	assign keystream_segment_tx_o = ks.seg_tx;
	assign keystream_segment_index_o = ks.seg_idx;
	// One mode per connection; new bearers copy these levels at setup
	assign tx_encrypt_o = tx_enc_q;
	assign rx_decrypt_o = rx_dec_q;
	assign rx_ignore_o = rx_ign_q;
	assign frame_even_o = !fn_q[0];

endmodule

// ==== testbench/cipher_mode_sync_control_asserts.sv ====
// Port-level checks on the cipher mode controller.
// Bound from the bench top; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module cipher_mode_sync_control_asserts
	import cipher_sync_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Inputs
	input wire logic fixed_role_i,
	input wire logic advanced_i,
	input wire logic [IV_LBN_W-1:0] logical_bearer_number_i,
	input wire logic key_wide_i,
	input wire logic frame_start_i,
	input wire logic rx_msg_valid_i,
	input wire logic [2:0] rx_msg_i,
	// Outputs
	input wire logic upper_switch_confirm_o,
	input wire logic upper_disconnect_indication_o,
	input wire logic tx_msg_valid_o,
	input wire logic tx_second_half_o,
	input wire logic keystream_generator_load_o,
	input wire logic [KEY_W-1:0] keystream_generator_key_o,
	input wire logic [IV_W-1:0] init_vector_o,
	input wire logic keystream_segment_valid_o,
	input wire logic [SEG_IDX_W-1:0] keystream_segment_index_o,
	input wire logic tx_encrypt_o,
	input wire logic rx_decrypt_o,
	input wire logic rx_ignore_o,
	input wire logic frame_even_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_conf;
		rx_msg_valid_i && rx_msg_i == MSG_ON_CONFIRM && !fixed_role_i && rx_ignore_o && !tx_encrypt_o;
	endsequence
	sequence s_frame_load;
		frame_start_i ##2 keystream_generator_load_o;
	endsequence
	AST_LOAD_AFTER_FRAME: assert property (keystream_generator_load_o |-> $past(frame_start_i, 2))
		else $error("load not two cycles after frame start");
	AST_IV_BASIC: assert property (keystream_generator_load_o && !advanced_i |-> init_vector_o[34:28] == 7'h0)
		else $error("basic vector top bits not zero");
	AST_IV_ADV: assert property (keystream_generator_load_o && advanced_i |->
		init_vector_o[31:28] == LBN_MAX - logical_bearer_number_i && init_vector_o[34:32] == 3'h0)
		else $error("advanced vector bearer field wrong");
	AST_IV_FRAME: assert property (keystream_generator_load_o |-> init_vector_o[0] != frame_even_o)
		else $error("vector frame bit disagrees with parity");
	AST_KEY_NARROW: assert property (keystream_generator_load_o && !key_wide_i |->
		keystream_generator_key_o[127:64] == 64'h0)
		else $error("narrow key upper half not zero");
	AST_TX_HALF: assert property (tx_msg_valid_o |-> tx_second_half_o == frame_even_o)
		else $error("tail half does not match frame parity");
	AST_TX_PARITY: assert property (tx_msg_valid_o |-> frame_even_o != fixed_role_i)
		else $error("tail message in wrong frame parity");
	AST_SEG_BOUND: assert property (keystream_segment_valid_o |-> keystream_segment_index_o <= 9'h167)
		else $error("segment index past end");
	AST_CONF_DECRYPT: assert property (s_conf |=> upper_switch_confirm_o && rx_decrypt_o && !rx_ignore_o)
		else $error("confirm did not start decryption");
	AST_DISC_CLEAR: assert property (upper_disconnect_indication_o |-> !tx_encrypt_o && !rx_decrypt_o)
		else $error("release left a mode set");
	AST_GRANT_ENC: assert property ($rose(tx_encrypt_o) && !fixed_role_i |-> tx_msg_valid_o)
		else $error("portable encryption began without grant");
	cover property (s_frame_load);
endmodule

// ==== testbench/peer_mac_model.sv ====
// Peer terminal: answers the block's tail messages one frame later, feeds generator bits.
// Assumes the bench drives frame_start_i and the kick, quiet and reject levels.
`timescale 1ns/1ps
module peer_mac_model
	import cipher_sync_pkg::*;
(
	// Clock and control
	input wire logic clk_i,
	input wire logic frame_start_i,
	input wire logic quiet_i,
	input wire logic rej_i,
	input wire logic kick_i,
	input wire logic [2:0] kick_code_i,
	// Block side
	input wire logic tx_valid_i,
	input wire logic [2:0] tx_msg_i,
	input wire logic tx_default_key_i,
	input wire logic load_i,
	output logic rx_valid_o = 0,
	output logic [2:0] rx_msg_o = 0,
	output logic rx_default_key_o,
	output logic bit_o = 0,
	output logic bit_valid_o = 0
);
	logic [2:0] pend = 0, tm;
	logic fs, tv, ld, kk;
	int left = 0;
	assign rx_default_key_o = rej_i;
	always @(posedge clk_i) begin
		// Sample before the edge's updates land, act after
		{fs, tv, tm, ld, kk} = {frame_start_i, tx_valid_i, tx_msg_i, load_i, kick_i};
		#1;
		rx_valid_o = 0;
		rx_msg_o = ~rx_msg_o;
		if (kk)
			pend = kick_code_i;
		if (tv && !quiet_i) begin
			case (tm)
				MSG_ON_REQUEST: pend = (rej_i && tx_default_key_i) ? MSG_ON_REJECT : MSG_ON_CONFIRM;
				MSG_OFF_REQUEST: pend = MSG_OFF_CONFIRM;
				MSG_ON_CONFIRM: pend = MSG_ON_GRANT;
				MSG_OFF_CONFIRM: pend = MSG_OFF_GRANT;
				default: ;
			endcase
		end
		if (fs && pend != 0) begin
			rx_valid_o = 1;
			rx_msg_o = pend;
			pend = 0;
		end
		if (ld)
			left = 720;
		bit_valid_o = left > 0;
		bit_o = left > 0 ? 1'($urandom) : ~bit_o;
		if (left > 0)
			left--;
	end
endmodule

// ==== testbench/test_cipher_mode_sync_control.sv ====
// Bench: peer model, per-bit reference of vectors and segments, handshake table.
// Assumes the package and the peer model are compiled first.
`timescale 1ns/1ps
module test_cipher_mode_sync_control;
	import cipher_sync_pkg::*;
	localparam int FRAME = 760;
	logic clk_i = 0, rst_n_i = 0, run = 0, quiet = 0, rej = 0, kick = 0;
	logic fixed_role_i = 0, advanced_i = 0, key_wide_i = 0, frame_start_i = 0, sync_i = 0;
	logic upper_switch_request_i = 0, upper_target_encrypt_i = 0, upper_default_key_i = 0;
	logic [2:0] kick_code = 0, rx_msg_i, tx_msg_o;
	logic [IV_LBN_W-1:0] logical_bearer_number = 0;
	logic [KEY_W-1:0] key = 0, key_o;
	logic [FN_W-1:0] sfn = 4'hb;
	logic [MF_W-1:0] smf = 24'hffffff;
	logic [27:0] fm = 0;
	logic [IV_W-1:0] iv_o;
	logic [SEG_IDX_W-1:0] sidx_o;
	logic rx_msg_valid_i, rx_default_key_i, gbit, gval, cfm, rjo, ind, disc, txv, tdk, load;
	logic sval, sbit, ssec, stx, tx_encrypt_o, rx_decrypt_o, rx_ignore_o, frame_even_o;
	int errors = 0, n_tests = 0, cyc = 0, sidx = 0, n_cfm, n_rej, n_disc, n_ind;
	logic [2:0] tx_log[$];
	logic gq[$];

	cipher_mode_sync_control i_cipher_mode_sync_control (.clk_i, .rst_n_i, .fixed_role_i,
		.advanced_i, .logical_bearer_number_i(logical_bearer_number), .key_wide_i, .cipher_key_i(key),
		.reject_default_i(rej), .frame_start_i, .sync_i, .sync_frame_i(sfn),
		.sync_multiframe_i(smf), .upper_switch_request_i, .upper_target_encrypt_i,
		.upper_default_key_i, .upper_switch_confirm_o(cfm), .upper_switch_reject_o(rjo),
		.upper_switch_indication_o(ind), .upper_disconnect_indication_o(disc),
		.rx_msg_valid_i, .rx_msg_i, .rx_default_key_i, .tx_msg_valid_o(txv), .tx_msg_o,
		.tx_default_key_o(tdk), .tx_second_half_o(), .keystream_generator_load_o(load),
		.keystream_generator_key_o(key_o), .init_vector_o(iv_o),
		.keystream_generator_bit_i(gbit), .keystream_generator_bit_valid_i(gval),
		.keystream_segment_valid_o(sval), .keystream_segment_bit_o(sbit),
		.keystream_segment_second_o(ssec), .keystream_segment_tx_o(stx),
		.keystream_segment_index_o(sidx_o), .tx_encrypt_o, .rx_decrypt_o, .rx_ignore_o,
		.frame_even_o);
	peer_mac_model i_peer_mac_model (.clk_i, .frame_start_i, .quiet_i(quiet), .rej_i(rej),
		.kick_i(kick), .kick_code_i(kick_code), .tx_valid_i(txv), .tx_msg_i(tx_msg_o),
		.tx_default_key_i(tdk), .load_i(load), .rx_valid_o(rx_msg_valid_i), .rx_msg_o(rx_msg_i),
		.rx_default_key_o(rx_default_key_i), .bit_o(gbit), .bit_valid_o(gval));

	task automatic chk(input string what, input logic [KEY_W-1:0] seen, input logic [KEY_W-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial forever #50 clk_i = ~clk_i;
	initial begin
		#(FRAME * 10000);
		errors++;
		end_sim;
	end

	// Frame timing; the model numbering advances as each start is issued
	always @(posedge clk_i) begin
		#1;
		frame_start_i = 0;
		if (run && ++cyc % FRAME == 0) begin
			frame_start_i = 1;
			fm++;
		end
	end

	always @(posedge clk_i) if (rst_n_i) begin
		if (txv === 1'b1)
			tx_log.push_back(tx_msg_o);
		n_cfm += cfm === 1'b1;
		n_rej += rjo === 1'b1;
		n_disc += disc === 1'b1;
		n_ind += ind === 1'b1;
		if (gval === 1'b1)
			gq.push_back(gbit);
		if (load === 1'b1) begin
			chk("bits per frame", sidx == 0 || sidx == 720, 1);
			sidx = 0;
			chk("init vector", iv_o, {3'h0, advanced_i ? LBN_MAX - logical_bearer_number : 4'h0, fm});
			chk("key", key_o, key_wide_i ? key : {64'h0, key[63:0]});
			chk("frame parity", frame_even_o, !fm[0]);
		end
		if (sval === 1'b1) begin
			chk("segment bit", sbit, gq.size() > 0 ? gq.pop_front() : 1'bx);
			chk("segment index", sidx_o, sidx % 360);
			chk("second segment", ssec, sidx >= 360);
			chk("tx direction", stx, fixed_role_i ? sidx < 360 : sidx >= 360);
			sidx++;
		end
	end

	task automatic run_case(input logic fx, tgt, q, rj, input int nf, en, ef, el, ec, ed, ei,
		input logic em);
		tx_log.delete();
		{n_cfm, n_rej, n_disc, n_ind} = 0;
		do @(posedge clk_i); while (!(frame_start_i && fm[0]));
		#1;
		{fixed_role_i, advanced_i, quiet, rej, upper_default_key_i, upper_target_encrypt_i} =
			{fx, fx, q, rj, rj, tgt};
		logical_bearer_number = 4'($urandom);
		key_wide_i = 1'($urandom);
		kick_code = tgt ? MSG_ON_REQUEST : MSG_OFF_REQUEST;
		{kick, upper_switch_request_i} = {fx, !fx};
		@(posedge clk_i);
		#1;
		{kick, upper_switch_request_i} = 0;
		repeat (nf * FRAME) @(posedge clk_i);
		chk("tail count", tx_log.size(), en);
		if (en > 0) begin
			chk("first tail", tx_log[0], ef);
			chk("last tail", tx_log[$], el);
		end
		chk("confirms", n_cfm, ec);
		chk("rejects", n_rej, rj && !fx);
		chk("releases", n_disc, ed);
		chk("indications", n_ind, ei);
		chk("modes", {tx_encrypt_o, rx_decrypt_o, rx_ignore_o}, {em, em, 1'b0});
	endtask

	initial begin
		void'($urandom(40));
		key = {$urandom, $urandom, $urandom, $urandom};
		repeat (8) @(posedge clk_i);
		#1;
		rst_n_i = 1;
		@(posedge clk_i);
		chk("clear after reset", {tx_encrypt_o, rx_decrypt_o, iv_o}, 0);
		#1;
		{sync_i, run} = 2'b11;
		fm = {smf, sfn};
		@(posedge clk_i);
		#1;
		sync_i = 0;
		run_case(0, 1, 0, 0, 4, 2, 1, 4, 1, 0, 0, 1);
		run_case(0, 0, 0, 0, 4, 2, 5, 7, 1, 0, 0, 0);
		run_case(0, 1, 1, 0, 14, 5, 1, 1, 0, 1, 0, 0);
		run_case(0, 1, 0, 1, 4, 1, 1, 1, 1, 0, 0, 0);
		run_case(1, 1, 0, 1, 4, 1, 3, 3, 0, 0, 0, 0);
		run_case(1, 1, 0, 0, 4, 1, 2, 2, 0, 0, 1, 1);
		run_case(1, 0, 1, 0, 15, 6, 6, 6, 0, 1, 0, 0);
		end_sim;
	end
endmodule

bind cipher_mode_sync_control cipher_mode_sync_control_asserts i_cipher_mode_sync_control_asserts (.*);
